//--- design/tlic_pkg.sv
// Constants, register map and source tables of the two-level interrupt controller
// Behaviour
// [RULE_01] Every source except nonmaskable gets one of two levels via two priority registers.
// [RULE_02] Three masking levels come from the global mask and user/mask bits.
// [RULE_03] Each source presents its own distinct vector number to the CPU.
// [RULE_04] Nonmaskable input wins always, ignores masks, detected on a chosen edge.
// [RULE_05] Each of six maskable inputs selects falling edge or low level on its own.
// [RULE_06] Seven external inputs: one nonmaskable and six active-low maskable requests.
// [RULE_07] Request flags accept only zero writes; writing 0 clears a flag.
// [RULE_08] System control loads 0x0B at reset and hardware standby, kept in software standby.
// [RULE_09] System control bit 3 at 0 makes the user bit a mask; at 1 plain.
// [RULE_10] System control bit 2 picks nonmaskable edge: 0 falling, 1 rising.
// [RULE_11] Priority register A is eight read/write bits, all zero after reset.
// [RULE_12] Register A bits map to requests 0,1,2-3,4-5, watchdog/refresh, timers 0-2.
// [RULE_13] Priority bit 0 gives level 0, priority bit 1 gives level 1.
// [RULE_14] Serve nonmaskable first, then level 1, then level 0, lowest vector first.
// [RULE_15] Global mask blocks all maskable; user bit as mask blocks level 0 only.
package tlic_pkg;

    localparam int ADDR_W = 18;
    localparam int NUM_EXT = 6;
    localparam int NUM_INT = 11;
    localparam int NUM_SRC = 17;

    // Register indices; byte address is four times the index
    localparam logic [15:0] IDX_SYSTEM_CONTROL = 16'hFFF2;
    localparam logic [15:0] IDX_REQUEST_SENSE_CONTROL = 16'hFFF4;
    localparam logic [15:0] IDX_REQUEST_ENABLE = 16'hFFF5;
    localparam logic [15:0] IDX_REQUEST_FLAGS = 16'hFFF6;
    localparam logic [15:0] IDX_PRIORITY_SELECT_A = 16'hFFF8;
    localparam logic [15:0] IDX_PRIORITY_SELECT_B = 16'hFFF9;

    localparam logic [7:0] RST_SYSTEM_CONTROL = 8'h0B;
    localparam logic [7:0] RST_ZERO = 8'h00;

    localparam int BIT_USER_BIT_ROLE_SELECT = 3;
    localparam int BIT_NONMASKABLE_EDGE_SELECT = 2;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    localparam logic [7:0] VEC_NONMASKABLE = 8'h07;

    // Source order: requests 0..5, watchdog, refresh, timer 0..4, dma, serial 0, serial 1, adc
    // Vector number of each source, rising with index
    localparam logic [7:0] SRC_VEC [NUM_SRC] = '{
        8'h0C, 8'h0D, 8'h0E, 8'h0F, 8'h10, 8'h11,
        8'h14, 8'h15, 8'h16, 8'h17, 8'h18, 8'h19, 8'h1A,
        8'h1B, 8'h1C, 8'h1D, 8'h1E
    };

    // Bit of {priority_select_b, priority_select_a} that sets each source's level
    localparam logic [3:0] SRC_PRIO_BIT [NUM_SRC] = '{
        4'h7, 4'h6, 4'h5, 4'h5, 4'h4, 4'h4,
        4'h3, 4'h3, 4'h2, 4'h1, 4'h0, 4'hF, 4'hE,
        4'hD, 4'hB, 4'hA, 4'h9
    };

endpackage : tlic_pkg

//--- design/tlic_controller.sv
// Two-level interrupt controller with an AXI4-Lite register slave
//
// Implementation choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
`default_nettype none
module tlic_controller
(
    input wire logic clk,                                   // System clock
    input wire logic reset_n,                               // Asynchronous reset
    input wire logic [tlic_pkg::ADDR_W-1:0] s_axi_awaddr,   // Write address
    input wire logic s_axi_awvalid,                         // Write address valid
    output logic s_axi_awready,                             // Write address ready
    input wire logic [31:0] s_axi_wdata,                    // Write data
    input wire logic [3:0] s_axi_wstrb,                     // Write strobes
    input wire logic s_axi_wvalid,                          // Write data valid
    output logic s_axi_wready,                              // Write data ready
    output logic [1:0] s_axi_bresp,                         // Write response
    output logic s_axi_bvalid,                              // Write response valid
    input wire logic s_axi_bready,                          // Write response ready
    input wire logic [tlic_pkg::ADDR_W-1:0] s_axi_araddr,   // Read address
    input wire logic s_axi_arvalid,                         // Read address valid
    output logic s_axi_arready,                             // Read address ready
    output logic [31:0] s_axi_rdata,                        // Read data
    output logic [1:0] s_axi_rresp,                         // Read response
    output logic s_axi_rvalid,                              // Read data valid
    input wire logic s_axi_rready,                          // Read data ready
    input wire logic nonmaskable_pin,                       // Nonmaskable input
    input wire logic [5:0] maskable_request_inputs_n,       // Maskable requests, low active
    input wire logic [10:0] internal_requests,              // On-chip module requests
    input wire logic hw_standby,                            // Hardware standby
    input wire logic ccr_global_mask,                       // Global mask bit of CPU
    input wire logic user_or_mask_bit,                      // User/mask bit of CPU
    input wire logic cpu_ack,                               // CPU takes the vector
    output logic irq_request,                               // Interrupt to CPU
    output logic [7:0] irq_vector,                          // Vector number
    output logic irq_nonmaskable,                           // Request is nonmaskable
    output logic irq_level                                  // Level of request
);

    // ****************************************************
    // Registers
    // ****************************************************
    logic [7:0] system_control;
    logic [5:0] request_sense_control;
    logic [5:0] request_enable;
    logic [5:0] request_flags;
    logic [7:0] priority_select_a;
    logic [7:0] priority_select_b;
    logic nonmaskable_pending;
    logic nonmaskable_prev;
    logic [5:0] request_prev_n;

    // ****************************************************
    // AXI4-Lite slave
    // ****************************************************
    logic aw_held;
    logic w_held;
    logic [tlic_pkg::ADDR_W-1:0] aw_addr;
    logic [31:0] w_data;
    logic w_lane0;
    logic do_write;
    logic [15:0] wr_idx;
    logic [15:0] rd_idx;
    logic wr_hit;
    logic rd_hit;
    logic [7:0] rd_value;

    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready = !w_held && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;
    assign do_write = aw_held && w_held && !s_axi_bvalid;
    assign wr_idx = aw_addr[17:2];
    assign rd_idx = s_axi_araddr[17:2];

    always_comb
    begin
        unique case (wr_idx)
            tlic_pkg::IDX_SYSTEM_CONTROL, tlic_pkg::IDX_REQUEST_SENSE_CONTROL,
            tlic_pkg::IDX_REQUEST_ENABLE, tlic_pkg::IDX_REQUEST_FLAGS,
            tlic_pkg::IDX_PRIORITY_SELECT_A, tlic_pkg::IDX_PRIORITY_SELECT_B:
                wr_hit = (aw_addr[1:0] == 2'h0);
            default:
                wr_hit = 1'b0;
        endcase
    end

    always_comb
    begin
        rd_hit = (s_axi_araddr[1:0] == 2'h0);
        unique case (rd_idx)
            tlic_pkg::IDX_SYSTEM_CONTROL: rd_value = system_control;
            tlic_pkg::IDX_REQUEST_SENSE_CONTROL: rd_value = {2'h0, request_sense_control};
            tlic_pkg::IDX_REQUEST_ENABLE: rd_value = {2'h0, request_enable};
            tlic_pkg::IDX_REQUEST_FLAGS: rd_value = {2'h0, request_flags};
            tlic_pkg::IDX_PRIORITY_SELECT_A: rd_value = priority_select_a;
            tlic_pkg::IDX_PRIORITY_SELECT_B: rd_value = priority_select_b;
            default:
            begin
                rd_value = 8'h00;
                rd_hit = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= '0;
            w_data <= 32'h0000_0000;
            w_lane0 <= 1'b0;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            else if (do_write)
                aw_held <= 1'b0;
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_lane0 <= s_axi_wstrb[0];
            end
            else if (do_write)
                w_held <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= tlic_pkg::RESP_OKAY;
        end
        else if (do_write)
        begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_hit ? tlic_pkg::RESP_OKAY : tlic_pkg::RESP_SLVERR;
        end
        else if (s_axi_bready)
            s_axi_bvalid <= 1'b0;
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= tlic_pkg::RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= {24'h000000, rd_value};
            s_axi_rresp <= rd_hit ? tlic_pkg::RESP_OKAY : tlic_pkg::RESP_SLVERR;
        end
        else if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
    end

    // ****************************************************
    // Control registers
    // ****************************************************
    logic wr_lane;
    assign wr_lane = do_write && wr_hit && w_lane0;

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            system_control <= tlic_pkg::RST_SYSTEM_CONTROL;
            request_sense_control <= 6'h00;
            request_enable <= 6'h00;
            priority_select_a <= tlic_pkg::RST_ZERO;
            priority_select_b <= tlic_pkg::RST_ZERO;
        end
        else if (hw_standby)
        begin
            system_control <= tlic_pkg::RST_SYSTEM_CONTROL; // [RULE_08]
            request_sense_control <= 6'h00;
            request_enable <= 6'h00;
            priority_select_a <= tlic_pkg::RST_ZERO; // [RULE_11]
            priority_select_b <= tlic_pkg::RST_ZERO;
        end
        else if (wr_lane)
        begin
            unique case (wr_idx)
                tlic_pkg::IDX_SYSTEM_CONTROL: system_control <= w_data[7:0];
                tlic_pkg::IDX_REQUEST_SENSE_CONTROL: request_sense_control <= w_data[5:0];
                tlic_pkg::IDX_REQUEST_ENABLE: request_enable <= w_data[5:0];
                tlic_pkg::IDX_PRIORITY_SELECT_A: priority_select_a <= w_data[7:0]; // [RULE_11]
                tlic_pkg::IDX_PRIORITY_SELECT_B: priority_select_b <= w_data[7:0]; // [RULE_01]
                default: ;
            endcase
        end
    end

    // ****************************************************
    // External request detection
    // ****************************************************
    logic [5:0] flag_set;
    logic [5:0] flag_keep;
    logic nonmaskable_edge;
    logic nm_rise_sel;

    // Sense bit 1 selects falling edge, 0 selects low level
    assign flag_set = (request_sense_control & request_prev_n & ~maskable_request_inputs_n)
                    | (~request_sense_control & ~maskable_request_inputs_n); // [RULE_05] [RULE_06]
    // Ones leave a flag alone, zeros clear it; a new event wins over the clear
    assign flag_keep = (wr_lane && wr_idx == tlic_pkg::IDX_REQUEST_FLAGS) ? w_data[5:0] : 6'h3F;
    assign nm_rise_sel = system_control[tlic_pkg::BIT_NONMASKABLE_EDGE_SELECT];
    assign nonmaskable_edge = nm_rise_sel ? (!nonmaskable_prev && nonmaskable_pin)
                                          : (nonmaskable_prev && !nonmaskable_pin); // [RULE_10]

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            request_prev_n <= 6'h3F;
            nonmaskable_prev <= 1'b1;
        end
        else
        begin
            request_prev_n <= maskable_request_inputs_n;
            nonmaskable_prev <= nonmaskable_pin;
        end
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            request_flags <= 6'h00;
        else if (hw_standby)
            request_flags <= 6'h00;
        else
            request_flags <= (request_flags & flag_keep) | flag_set; // [RULE_07]
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            nonmaskable_pending <= 1'b0;
        else if (hw_standby)
            nonmaskable_pending <= 1'b0;
        else if (nonmaskable_edge)
            nonmaskable_pending <= 1'b1; // [RULE_04]
        else if (cpu_ack && irq_nonmaskable)
            nonmaskable_pending <= 1'b0;
    end

    // ****************************************************
    // Arbitration
    // ****************************************************
    logic [15:0] prio_bits;
    logic [tlic_pkg::NUM_SRC-1:0] src_active;
    logic [tlic_pkg::NUM_SRC-1:0] src_level;
    logic user_mask_on;
    logic any1;
    logic any0;
    logic [7:0] vec1;
    logic [7:0] vec0;
    logic next_irq_request;
    logic [7:0] next_irq_vector;
    logic next_irq_nonmaskable;
    logic next_irq_level;

    assign prio_bits = {priority_select_b, priority_select_a};
    assign src_active = {internal_requests, request_flags & request_enable};
    assign user_mask_on = !system_control[tlic_pkg::BIT_USER_BIT_ROLE_SELECT]
                       && user_or_mask_bit; // [RULE_09]

    genvar g;
    generate
        for (g = 0; g < tlic_pkg::NUM_SRC; g++)
        begin : gen_level
            assign src_level[g] = prio_bits[tlic_pkg::SRC_PRIO_BIT[g]]; // [RULE_12] [RULE_13]
        end
    endgenerate

    // Scan downward so the lowest vector of each level is left selected
    always_comb
    begin
        any1 = 1'b0;
        any0 = 1'b0;
        vec1 = 8'h00;
        vec0 = 8'h00;
        for (int i = tlic_pkg::NUM_SRC - 1; i >= 0; i--)
        begin
            if (src_active[i] && src_level[i])
            begin
                any1 = 1'b1;
                vec1 = tlic_pkg::SRC_VEC[i]; // [RULE_03]
            end
            if (src_active[i] && !src_level[i])
            begin
                any0 = 1'b1;
                vec0 = tlic_pkg::SRC_VEC[i];
            end
        end
    end

    always_comb
    begin
        next_irq_request = 1'b1;
        next_irq_nonmaskable = 1'b0;
        next_irq_level = 1'b0;
        next_irq_vector = 8'h00;
        if (nonmaskable_pending)
        begin
            next_irq_nonmaskable = 1'b1; // [RULE_04] [RULE_14]
            next_irq_vector = tlic_pkg::VEC_NONMASKABLE;
        end
        else if (ccr_global_mask)
            next_irq_request = 1'b0; // [RULE_02] [RULE_15]
        else if (any1)
        begin
            next_irq_level = 1'b1; // [RULE_14]
            next_irq_vector = vec1;
        end
        else if (any0 && !user_mask_on)
            next_irq_vector = vec0; // [RULE_15]
        else
            next_irq_request = 1'b0;
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            irq_request <= 1'b0;
            irq_vector <= 8'h00;
            irq_nonmaskable <= 1'b0;
            irq_level <= 1'b0;
        end
        else
        begin
            irq_request <= next_irq_request;
            irq_vector <= next_irq_vector;
            irq_nonmaskable <= next_irq_nonmaskable;
            irq_level <= next_irq_level;
        end
    end

    // ****************************************************
    // Checks
    // ****************************************************
    chk_nm_wins: assert property (@(posedge clk) disable iff (!reset_n) // [RULE_04]
        nonmaskable_pending |=> irq_nonmaskable && irq_request && irq_vector == 8'h07)
        else $error("Pending nonmaskable request not presented");
    chk_nm_edge: assert property (@(posedge clk) disable iff (!reset_n) // [RULE_10]
        (!hw_standby && !nm_rise_sel && $past(nonmaskable_pin) && !nonmaskable_pin)
        |=> nonmaskable_pending)
        else $error("Selected nonmaskable edge missed");
    chk_global_mask: assert property (@(posedge clk) disable iff (!reset_n) // [RULE_15]
        (ccr_global_mask && !nonmaskable_pending) |=> !irq_request)
        else $error("Maskable request passed global mask");
    chk_user_mask: assert property (@(posedge clk) disable iff (!reset_n) // [RULE_09]
        (user_mask_on && !ccr_global_mask && !nonmaskable_pending)
        |=> (!irq_request || irq_level))
        else $error("Level 0 request passed user mask");
    chk_level_order: assert property (@(posedge clk) disable iff (!reset_n) // [RULE_14]
        (any1 && !ccr_global_mask && !nonmaskable_pending) |=> irq_request && irq_level)
        else $error("Level 1 request not served first");
    chk_edge_flag: assert property (@(posedge clk) disable iff (!reset_n) // [RULE_05]
        (!hw_standby && request_sense_control[0] && request_prev_n[0]
         && !maskable_request_inputs_n[0]) |=> request_flags[0])
        else $error("Falling edge did not set flag");
    chk_flag_ones: assert property (@(posedge clk) disable iff (!reset_n) // [RULE_07]
        (!hw_standby && request_flags[1] && wr_lane && wr_idx == tlic_pkg::IDX_REQUEST_FLAGS
         && w_data[1]) |=> request_flags[1])
        else $error("Writing one cleared a flag");
    chk_standby_init: assert property (@(posedge clk) disable iff (!reset_n) // [RULE_08]
        hw_standby |=> system_control == 8'h0B && priority_select_a == 8'h00)
        else $error("Standby did not initialise registers");
    chk_prio_a_write: assert property (@(posedge clk) disable iff (!reset_n) // [RULE_11]
        (!hw_standby && wr_lane && wr_idx == tlic_pkg::IDX_PRIORITY_SELECT_A)
        |=> priority_select_a == $past(w_data[7:0]))
        else $error("Priority register A write lost");

endmodule : tlic_controller
`default_nettype wire

//--- tb/tlic_cpu_model.sv
// CPU core model that takes nonmaskable vectors from the controller
`timescale 1ns/1ns
`default_nettype none
module tlic_cpu_model
(
    input wire logic clk,               // System clock
    input wire logic reset_n,           // Asynchronous reset
    input wire logic irq_request,       // Interrupt from controller
    input wire logic irq_nonmaskable,   // Presented request is nonmaskable
    input wire logic ack_en,            // Bench lets the core take vectors
    output logic cpu_ack                // One-cycle vector take
);
    // ************************************************************
    // Vector take
    // ************************************************************
    // Gap after each pulse lets the pending state fall before the next look
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            cpu_ack <= 1'b0;
        else
            cpu_ack <= ack_en & irq_request & irq_nonmaskable & ~cpu_ack;
    end
endmodule : tlic_cpu_model
`default_nettype wire

//--- tb/tlic_controller_tb_top.sv
// Testbench for the two-level interrupt controller
`timescale 1ns/1ns
`default_nettype none
module tlic_controller_tb_top;
    localparam logic [15:0] SC = tlic_pkg::IDX_SYSTEM_CONTROL;
    localparam logic [15:0] FL = tlic_pkg::IDX_REQUEST_FLAGS;
    localparam logic [15:0] PA = tlic_pkg::IDX_PRIORITY_SELECT_A;
    localparam logic [15:0] PB = tlic_pkg::IDX_PRIORITY_SELECT_B;
    localparam logic [1:0] OK = tlic_pkg::RESP_OKAY;
    logic clk = 1'b0, reset_n = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
    logic s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic irq_request, irq_nonmaskable, irq_level, cpu_ack, ack_en = 1'b0;
    logic nonmaskable_pin = 1'b1, hw_standby = 1'b0;
    logic ccr_global_mask = 1'b0, user_or_mask_bit = 1'b0;
    logic [tlic_pkg::ADDR_W-1:0] s_axi_awaddr = 18'h0, s_axi_araddr = 18'h0;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [5:0] maskable_request_inputs_n = 6'h3F;
    logic [10:0] internal_requests = 11'h000;
    logic [7:0] irq_vector;
    int error_cnt = 0;
    int total_checks = 0;

    tlic_controller i_tlic_controller
    (
        .clk, .reset_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .nonmaskable_pin,
        .maskable_request_inputs_n, .internal_requests, .hw_standby, .ccr_global_mask,
        .user_or_mask_bit, .cpu_ack, .irq_request, .irq_vector, .irq_nonmaskable, .irq_level
    );

    tlic_cpu_model i_tlic_cpu_model
    (
        .clk, .reset_n, .irq_request, .irq_nonmaskable, .ack_en, .cpu_ack
    );

    always #5 clk = ~clk;

    // ************************************************************
    // Shared tasks
    // ************************************************************
    task automatic end_sim;
        begin
            $display("Checks %0d, mismatches %0d", total_checks, error_cnt);
            if (error_cnt == 0 && total_checks > 0)
                $display("Test passed");
            else
                $display("Test failed");
            $finish;
        end
    endtask : end_sim

    task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // Ready is sampled mid-cycle; inputs only move at rising edges
    task automatic axw(input logic [15:0] idx, input logic [7:0] d, output logic [1:0] r);
        logic aw, w, b;
        begin
            s_axi_awaddr <= {idx, 2'b00};
            s_axi_wdata <= {24'h000000, d};
            s_axi_awvalid <= 1'b1;
            s_axi_wvalid <= 1'b1;
            s_axi_bready <= 1'b1;
            b = 1'b0;
            for (int n = 0; n < 50 && !b; n++)
            begin
                @(negedge clk);
                aw = s_axi_awvalid & s_axi_awready;
                w = s_axi_wvalid & s_axi_wready;
                b = s_axi_bvalid & s_axi_bready;
                r = s_axi_bresp;
                @(posedge clk);
                if (aw)
                    s_axi_awvalid <= 1'b0;
                if (w)
                    s_axi_wvalid <= 1'b0;
                if (b)
                    s_axi_bready <= 1'b0;
            end
            if (!b)
            begin
                error_cnt++;
                end_sim();
            end
            @(posedge clk);
        end
    endtask : axw

    task automatic rdc(input logic [15:0] idx, input logic [7:0] exp, input logic [1:0] er);
        logic ar, rv;
        logic [31:0] d;
        logic [1:0] r;
        begin
            s_axi_araddr <= {idx, 2'b00};
            s_axi_arvalid <= 1'b1;
            s_axi_rready <= 1'b1;
            rv = 1'b0;
            for (int n = 0; n < 50 && !rv; n++)
            begin
                @(negedge clk);
                ar = s_axi_arvalid & s_axi_arready;
                rv = s_axi_rvalid & s_axi_rready;
                d = s_axi_rdata;
                r = s_axi_rresp;
                @(posedge clk);
                if (ar)
                    s_axi_arvalid <= 1'b0;
                if (rv)
                    s_axi_rready <= 1'b0;
            end
            if (!rv)
            begin
                error_cnt++;
                end_sim();
            end
            @(posedge clk);
            chk({d[31:0], r}, {24'h000000, exp, er});
        end
    endtask : rdc

    task automatic wr(input logic [15:0] idx, input logic [7:0] d);
        logic [1:0] r;
        begin
            axw(idx, d, r);
            chk(r, OK);
        end
    endtask : wr

    // Compare the interrupt outputs half a cycle after three rising edges have passed
    task automatic irq_chk(input logic q, input logic [7:0] v, input logic nm, input logic lv);
        logic [10:0] s;
        begin
            repeat (3) @(posedge clk);
            @(negedge clk);
            s = {irq_request, irq_vector, irq_nonmaskable, irq_level};
            chk(s, {q, v, nm, lv});
            @(posedge clk);
        end
    endtask : irq_chk

    // ************************************************************
    // Scenarios
    // ************************************************************
    task automatic t_regs;
        logic [15:0] idx [6];
        logic [7:0] rst [6];
        logic [1:0] r;
        begin
            idx = '{SC, 16'hFFF4, 16'hFFF5, FL, PA, PB};
            rst = '{8'h0B, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
            for (int i = 0; i < 6; i++)
                rdc(idx[i], rst[i], OK);
            wr(PA, 8'hA5);
            rdc(PA, 8'hA5, OK);
            wr(PB, 8'h5A);
            rdc(PB, 8'h5A, OK);
            axw(16'hFFF3, 8'h11, r);
            chk(r, tlic_pkg::RESP_SLVERR);
            rdc(16'hFFF3, 8'h00, tlic_pkg::RESP_SLVERR);
            wr(FL, 8'hFF);
            rdc(FL, 8'h00, OK);
            wr(PA, 8'h00);
            wr(PB, 8'h00);
            $display("Test t_regs finished");
        end
    endtask : t_regs

    task automatic t_edge;
        wr(16'hFFF4, 8'h01);
        wr(16'hFFF5, 8'h03);
        maskable_request_inputs_n <= 6'h3E;
        irq_chk(1'b1, 8'h0C, 1'b0, 1'b0);
        maskable_request_inputs_n <= 6'h3F;
        irq_chk(1'b1, 8'h0C, 1'b0, 1'b0);
        rdc(FL, 8'h01, OK);
        wr(FL, 8'h00);
        irq_chk(1'b0, 8'h00, 1'b0, 1'b0);
        maskable_request_inputs_n <= 6'h3D;
        irq_chk(1'b1, 8'h0D, 1'b0, 1'b0);
        $display("Test t_edge finished");
    endtask : t_edge

    task automatic t_prio;
        internal_requests <= 11'h001;
        irq_chk(1'b1, 8'h0D, 1'b0, 1'b0);
        wr(PA, 8'h08);
        irq_chk(1'b1, 8'h14, 1'b0, 1'b1);
        ccr_global_mask <= 1'b1;
        irq_chk(1'b0, 8'h00, 1'b0, 1'b0);
        ccr_global_mask <= 1'b0;
        internal_requests <= 11'h000;
        user_or_mask_bit <= 1'b1;
        irq_chk(1'b1, 8'h0D, 1'b0, 1'b0);
        wr(SC, 8'h03);
        irq_chk(1'b0, 8'h00, 1'b0, 1'b0);
        internal_requests <= 11'h001;
        irq_chk(1'b1, 8'h14, 1'b0, 1'b1);
        internal_requests <= 11'h000;
        user_or_mask_bit <= 1'b0;
        maskable_request_inputs_n <= 6'h3F;
        wr(FL, 8'h02);
        rdc(FL, 8'h02, OK);
        wr(FL, 8'h00);
        wr(SC, 8'h0B);
        irq_chk(1'b0, 8'h00, 1'b0, 1'b0);
        $display("Test t_prio finished");
    endtask : t_prio

    task automatic t_nmi;
        ccr_global_mask <= 1'b1;
        nonmaskable_pin <= 1'b0;
        irq_chk(1'b1, 8'h07, 1'b1, 1'b0);
        ack_en <= 1'b1;
        irq_chk(1'b0, 8'h00, 1'b0, 1'b0);
        ack_en <= 1'b0;
        wr(SC, 8'h0F);
        nonmaskable_pin <= 1'b1;
        irq_chk(1'b1, 8'h07, 1'b1, 1'b0);
        ack_en <= 1'b1;
        irq_chk(1'b0, 8'h00, 1'b0, 1'b0);
        ack_en <= 1'b0;
        nonmaskable_pin <= 1'b0;
        irq_chk(1'b0, 8'h00, 1'b0, 1'b0);
        ccr_global_mask <= 1'b0;
        $display("Test t_nmi finished");
    endtask : t_nmi

    task automatic t_standby;
        wr(SC, 8'h03);
        wr(PA, 8'h81);
        hw_standby <= 1'b1;
        @(posedge clk);
        hw_standby <= 1'b0;
        @(posedge clk);
        rdc(SC, 8'h0B, OK);
        rdc(PA, 8'h00, OK);
        $display("Test t_standby finished");
    endtask : t_standby

    initial
    begin
        repeat (6) @(posedge clk);
        reset_n <= 1'b1;
        @(posedge clk);
        t_regs();
        t_edge();
        t_prio();
        t_nmi();
        t_standby();
        end_sim();
    end
endmodule : tlic_controller_tb_top
`default_nettype wire
